//--- rtl/ubrg_pkg.sv
// package for the serial baud rate generator: offsets, fields, reset values, timing counts
// assumes a 100 MHz system clock and an AXI4-Lite register bus with 32-bit data
package ubrg_pkg;
	localparam logic [7:0] ADDR_CLKSEL = 8'h00;
	localparam logic [7:0] ADDR_DIVISOR = 8'h04;
	localparam logic [7:0] ADDR_MODE = 8'h08;
	localparam logic [7:0] ADDR_TXSTAT = 8'h0C;
	localparam logic [7:0] ADDR_TXBUF = 8'h10;
	localparam logic [7:0] ADDR_RXBUF = 8'h14;
	localparam int MODE_UNIT_BIT = 0;
	localparam int MODE_TX_BIT = 1;
	localparam int MODE_RX_BIT = 2;
	localparam logic [3:0] CLKSEL_RESET = 4'h0;
	localparam logic [7:0] DIVISOR_RESET = 8'hFF;
	localparam logic [3:0] SEL_MAX_DIV = 4'hA;
	localparam logic [3:0] SEL_EXT = 4'hB;
	localparam logic [7:0] DIV_MIN = 8'h08;
	localparam int FRAME_BITS = 11;
	localparam int DATA_BITS = 8;
	localparam logic [1:0] STOP_EXTRA = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : ubrg_pkg

//--- rtl/ubrg_prescaler.sv
// base clock tick generator: power-of-two divider or external clock edge
// assumes the external clock input is synchronous to clk_sys
`timescale 1ns/1ps
module ubrg_prescaler
	import ubrg_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset
	input wire logic unit_en, // serial unit enable
	input wire logic [3:0] sel, // base clock select code
	input wire logic ext_clk, // external baud clock
	output logic base_tick // one cycle per base clock rising edge
);
	logic [9:0] div_cnt_ff;
	logic ext_prev_ff;
	logic [10:0] mask;

	always_ff @(posedge clk_sys) begin
		if (rst || !unit_en) begin
			div_cnt_ff <= 10'h000;
		end else begin
			div_cnt_ff <= div_cnt_ff + 10'h001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ext_prev_ff <= 1'b0;
		end else begin
			ext_prev_ff <= ext_clk;
		end
	end

	// tick when low code bits of the free counter are all ones
	assign mask = (11'h001 << sel) - 11'h001;

	always_comb begin
		base_tick = 1'b0;
		if (unit_en) begin
			if (sel <= SEL_MAX_DIV) begin
				base_tick = ((div_cnt_ff & mask[9:0]) == mask[9:0]);
			end else if (sel == SEL_EXT) begin
				base_tick = ext_clk && !ext_prev_ff;
			end
		end
	end

	AST_NO_TICK_DISABLED: assert property (@(posedge clk_sys) disable iff (rst)
		!unit_en |-> !base_tick) else $error("base tick while unit disabled");
	AST_DIV_NO_BACK_TO_BACK: assert property (@(posedge clk_sys) disable iff (rst)
		(unit_en && $past(unit_en) && sel != 4'h0 && sel <= SEL_MAX_DIV
		&& $stable(sel) && base_tick)
		|=> !base_tick) else $error("divided base clock ticked twice in a row");
endmodule : ubrg_prescaler

//--- rtl/ubrg_top.sv
// serial baud generator with transmitter and receiver timing, AXI4-Lite registers
// assumes clk_sys at 100 MHz and serial pins synchronous to clk_sys
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module ubrg_top
	import ubrg_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic external_baud_clock_in, // external base clock
	input wire logic serial_in_pin, // serial receive input
	output logic serial_out_pin // serial transmit output
);
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_SHIFT = 4'b0010,
		TX_STRETCH = 4'b0100,
		TX_UNUSED = 4'b1000
	} ubrg_tx_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b001,
		RX_START = 3'b010,
		RX_DATA = 3'b100
	} ubrg_rx_t;

	logic [3:0] base_clock_select_field_ff;
	logic [7:0] divisor_value_field_ff;
	logic serial_unit_enable_ff, transmit_enable_bit_ff, receive_enable_bit_ff;
	logic [7:0] transmit_holding_buffer_ff;
	logic tx_buffer_full_flag_ff;
	logic [7:0] rx_data_ff;
	logic rx_ready_ff;
	logic base_tick;
	logic aw_hold_ff, w_hold_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic wr_go, wr_ok, txbuf_wr, rd_go, rd_rxbuf;
	logic [31:0] nxt_rdata;
	logic [1:0] nxt_rresp;
	logic tx_shift_busy;

	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_hold_ff && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_ff && !s_axi_bvalid;
	assign wr_go = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
	assign wr_ok = aw_addr_ff inside {ADDR_CLKSEL, ADDR_DIVISOR, ADDR_MODE, ADDR_TXBUF};
	assign txbuf_wr = wr_go && aw_addr_ff == ADDR_TXBUF && w_strb_ff[0];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff <= 1'b1;
				aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
			end else if (wr_go) begin
				aw_hold_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end else if (wr_go) begin
				w_hold_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// configuration registers; only byte lane 0 carries data
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			base_clock_select_field_ff <= CLKSEL_RESET;
			divisor_value_field_ff <= DIVISOR_RESET;
			serial_unit_enable_ff <= 1'b0;
			transmit_enable_bit_ff <= 1'b0;
			receive_enable_bit_ff <= 1'b0;
		end else if (wr_go && w_strb_ff[0]) begin
			unique case (aw_addr_ff)
				ADDR_CLKSEL: base_clock_select_field_ff <= w_data_ff[3:0];
				ADDR_DIVISOR: divisor_value_field_ff <= w_data_ff[7:0];
				ADDR_MODE: begin
					serial_unit_enable_ff <= w_data_ff[MODE_UNIT_BIT];
					transmit_enable_bit_ff <= w_data_ff[MODE_TX_BIT];
					receive_enable_bit_ff <= w_data_ff[MODE_RX_BIT];
				end
				default: ;
			endcase
		end
	end

	// read channel, one-cycle answer
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign rd_rxbuf = rd_go && {s_axi_araddr[7:2], 2'b00} == ADDR_RXBUF;

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		nxt_rresp = RESP_OKAY;
		unique case ({s_axi_araddr[7:2], 2'b00})
			ADDR_CLKSEL: nxt_rdata[3:0] = base_clock_select_field_ff;
			ADDR_DIVISOR: nxt_rdata[7:0] = divisor_value_field_ff;
			ADDR_MODE: nxt_rdata[2:0] = {receive_enable_bit_ff, transmit_enable_bit_ff,
				serial_unit_enable_ff};
			ADDR_TXSTAT: nxt_rdata[1:0] = {tx_buffer_full_flag_ff, tx_shift_busy};
			ADDR_RXBUF: nxt_rdata[8:0] = {rx_ready_ff, rx_data_ff};
			default: nxt_rresp = RESP_SLVERR;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= nxt_rdata;
			s_axi_rresp <= nxt_rresp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	ubrg_prescaler u_prescaler (
		.clk_sys(clk_sys),
		.rst(rst),
		.unit_en(serial_unit_enable_ff),
		.sel(base_clock_select_field_ff),
		.ext_clk(external_baud_clock_in),
		.base_tick(base_tick)
	);

	// transmitter: k base clocks per half bit, two halves per bit
	ubrg_tx_t tx_state_ff;
	logic [7:0] tx_cnt_ff;
	logic tx_half_ff;
	logic [3:0] tx_bit_ff;
	logic [9:0] tx_shift_ff;
	logic [1:0] tx_ext_ff;
	logic tx_on, tx_bit_end, tx_load;

	assign tx_on = serial_unit_enable_ff && transmit_enable_bit_ff;
	assign tx_shift_busy = tx_state_ff != TX_IDLE;
	assign tx_bit_end = base_tick && tx_half_ff && tx_cnt_ff == divisor_value_field_ff
		- 8'h01;
	// frames start on a base tick so the start bit is a full bit long
	assign tx_load = base_tick && tx_buffer_full_flag_ff && (tx_state_ff == TX_IDLE
		|| (tx_state_ff == TX_STRETCH && tx_ext_ff == STOP_EXTRA - 2'h1));

	always_ff @(posedge clk_sys) begin
		if (rst || !tx_on) begin
			tx_buffer_full_flag_ff <= 1'b0;
			transmit_holding_buffer_ff <= 8'h00;
		end else if (txbuf_wr && !tx_buffer_full_flag_ff) begin
			tx_buffer_full_flag_ff <= 1'b1;
			transmit_holding_buffer_ff <= w_data_ff[7:0];
		end else if (tx_load) begin
			tx_buffer_full_flag_ff <= 1'b0;
		end
	end

	// tx divide counter; cleared outside TX_SHIFT, freezes in TX_SHIFT whenever no base tick arrives
	always_ff @(posedge clk_sys) begin
		if (rst || !tx_on || tx_state_ff != TX_SHIFT) begin
			tx_cnt_ff <= 8'h00;
			tx_half_ff <= 1'b0;
		end else if (base_tick) begin
			if (tx_state_ff == TX_SHIFT && tx_cnt_ff == divisor_value_field_ff - 8'h01) begin
				tx_cnt_ff <= 8'h00;
				tx_half_ff <= !tx_half_ff;
			end else begin
				tx_cnt_ff <= tx_cnt_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || !tx_on) begin
			tx_state_ff <= TX_IDLE;
			tx_bit_ff <= 4'h0;
			tx_shift_ff <= 10'h3FF;
			tx_ext_ff <= 2'h0;
		end else begin
			unique case (tx_state_ff)
				TX_IDLE: if (tx_load) begin
					tx_state_ff <= TX_SHIFT;
					tx_shift_ff <= {1'b1, transmit_holding_buffer_ff, 1'b0};
					tx_bit_ff <= 4'h0;
				end
				TX_SHIFT: if (tx_bit_end) begin
					tx_bit_ff <= tx_bit_ff + 4'h1;
					tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
					if (tx_bit_ff == 4'(DATA_BITS + 1)) begin
						tx_state_ff <= TX_STRETCH;
						tx_ext_ff <= 2'h0;
					end
				end
				TX_STRETCH: if (base_tick) begin
					tx_ext_ff <= tx_ext_ff + 2'h1;
					if (tx_load) begin
						tx_state_ff <= TX_SHIFT;
						tx_shift_ff <= {1'b1, transmit_holding_buffer_ff, 1'b0};
						tx_bit_ff <= 4'h0;
					end else if (tx_ext_ff == STOP_EXTRA - 2'h1) begin
						tx_state_ff <= TX_IDLE;
					end
				end
				default: tx_state_ff <= TX_IDLE;
			endcase
		end
	end

	// output holds its last level while the base clock is stopped and the transmitter stays enabled
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			serial_out_pin <= 1'b1;
		end else begin
			serial_out_pin <= tx_shift_ff[0];
		end
	end

	// receiver: two-sample filter then centre sampling
	ubrg_rx_t rx_state_ff;
	logic [1:0] rx_samp_ff;
	logic rx_level_ff;
	logic [8:0] rx_cnt_ff;
	logic [3:0] rx_bit_ff;
	logic [7:0] rx_shift_ff;
	logic rx_on;
	logic [8:0] rx_full;

	assign rx_on = serial_unit_enable_ff && receive_enable_bit_ff;
	assign rx_full = {divisor_value_field_ff, 1'b0};

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rx_samp_ff <= 2'b11;
			rx_level_ff <= 1'b1;
		end else if (base_tick) begin
			rx_samp_ff <= {rx_samp_ff[0], serial_in_pin};
			if (rx_samp_ff[1] == rx_samp_ff[0]) begin
				rx_level_ff <= rx_samp_ff[0];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || !rx_on) begin
			rx_state_ff <= RX_IDLE;
			rx_cnt_ff <= 9'h000;
			rx_bit_ff <= 4'h0;
			rx_shift_ff <= 8'h00;
		end else if (base_tick) begin
			unique case (rx_state_ff)
				RX_IDLE: if (!rx_level_ff) begin
					rx_state_ff <= RX_START;
					rx_cnt_ff <= 9'h001;
				end
				RX_START: if (rx_cnt_ff == {1'b0, divisor_value_field_ff}) begin
					rx_cnt_ff <= 9'h001;
					rx_state_ff <= rx_level_ff ? RX_IDLE : RX_DATA;
					rx_bit_ff <= 4'h0;
				end else begin
					rx_cnt_ff <= rx_cnt_ff + 9'h001;
				end
				RX_DATA: if (rx_cnt_ff == rx_full) begin
					rx_cnt_ff <= 9'h001;
					rx_bit_ff <= rx_bit_ff + 4'h1;
					if (rx_bit_ff == 4'(DATA_BITS)) begin
						rx_state_ff <= RX_IDLE;
					end else begin
						rx_shift_ff <= {rx_level_ff, rx_shift_ff[7:1]};
					end
				end else begin
					rx_cnt_ff <= rx_cnt_ff + 9'h001;
				end
				default: rx_state_ff <= RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rx_data_ff <= 8'h00;
			rx_ready_ff <= 1'b0;
		end else if (rx_on && base_tick && rx_state_ff == RX_DATA && rx_cnt_ff == rx_full
			&& rx_bit_ff == 4'(DATA_BITS) && rx_level_ff) begin
			rx_data_ff <= rx_shift_ff;
			rx_ready_ff <= 1'b1;
		end else if (rd_rxbuf) begin
			rx_ready_ff <= 1'b0;
		end
	end

	AST_TX_IDLE_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
		(tx_state_ff == TX_IDLE && $past(tx_state_ff) == TX_IDLE) |-> serial_out_pin)
		else $error("line not idle high");
	AST_STRETCH_TWO: assert property (@(posedge clk_sys) disable iff (rst)
		(tx_state_ff == TX_STRETCH && tx_ext_ff == 2'h1 && base_tick && tx_on)
		|=> tx_state_ff == ($past(tx_buffer_full_flag_ff) ? TX_SHIFT : TX_IDLE))
		else $error("stop stretch length wrong");
	AST_FREEZE: assert property (@(posedge clk_sys) disable iff (rst)
		(!base_tick && !txbuf_wr && tx_on && $past(tx_on) && tx_state_ff == TX_SHIFT)
		|=> $stable(tx_cnt_ff)) else $error("tx counter moved without base clock");
	AST_BUF_FLAGS: assert property (@(posedge clk_sys) disable iff (rst)
		(tx_load && tx_on) |=>
		(!tx_buffer_full_flag_ff && tx_shift_busy)) else $error("buffer handoff wrong");
	AST_RX_FILTER: assert property (@(posedge clk_sys) disable iff (rst)
		(base_tick && rx_samp_ff[1] != rx_samp_ff[0]) |=> $stable(rx_level_ff))
		else $error("filter passed a single sample");
	AST_CLKSEL_READ: assert property (@(posedge clk_sys) disable iff (rst)
		(rd_go && {s_axi_araddr[7:2], 2'b00} == ADDR_CLKSEL) |=> s_axi_rdata[31:4] == 28'h0)
		else $error("select upper bits not zero");
	AST_RX_START_CENTRE: assert property (@(posedge clk_sys) disable iff (rst)
		(rx_state_ff == RX_START && base_tick && rx_on && rx_cnt_ff > divisor_value_field_ff)
		|-> 1'b0) else $error("start centre overshoot");
	AST_TX_RATE: assert property (@(posedge clk_sys) disable iff (rst)
		(tx_on && tx_state_ff == TX_SHIFT && base_tick && tx_cnt_ff >= divisor_value_field_ff)
		|-> 1'b0) else $error("tx counter beyond divisor");
endmodule : ubrg_top

//--- verif/ubrg_peer.sv
// remote serial peer: sends frames into the receive pin, decodes frames from the transmit pin
// assumes an idle-high line and bit periods in clk_sys cycles set by the bench
`timescale 1ns/1ps
module ubrg_peer (
	input wire logic clk_sys, // system clock
	input wire logic line_in, // device serial output
	output logic line_out, // device serial input
	output logic [7:0] rx_byte, // last decoded byte
	output logic rx_valid, // one cycle per decoded frame
	output int gap // cycles between the last two start edges
);
	int bit_cyc = 16;
	int cyc = 0;
	int last_t0 = 0;
	always @(posedge clk_sys) cyc <= cyc + 1;
	initial begin
		line_out = 1'b1;
		rx_byte = 8'h00;
		rx_valid = 1'b0;
		gap = 0;
	end
	// one 8N1 frame, lsb first, per cycles a bit; a skewed per models the peer's rate error
	task automatic send(input logic [7:0] b, input int per);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_out <= fr[i];
			repeat (per) @(posedge clk_sys);
		end
	endtask : send
	// low pulse of w cycles, meant to be rejected as noise
	task automatic pulse(input int w);
		line_out <= 1'b0;
		repeat (w) @(posedge clk_sys);
		line_out <= 1'b1;
	endtask : pulse
	// each start edge restarts the timing; bits are taken at mid-bit
	always begin
		@(negedge line_in);
		@(posedge clk_sys);
		gap = cyc - last_t0;
		last_t0 = cyc;
		repeat (bit_cyc / 2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_cyc) @(posedge clk_sys);
			rx_byte[i] = line_in;
		end
		repeat (bit_cyc) @(posedge clk_sys);
		rx_valid <= 1'b1;
		@(posedge clk_sys);
		rx_valid <= 1'b0;
	end
endmodule : ubrg_peer

//--- verif/ubrg_top_tb.sv
// testbench for the serial baud generator: registers, transmit and receive bit timing
// assumes the peer model on the serial pins and clk_sys at 100 MHz
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module ubrg_top_tb
	import ubrg_pkg::*;
;
	logic clk_sys, rst, ext_clk, ser_rx, ser_tx, peer_valid;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, peer_byte;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int peer_gap, fail_count, samples_checked;
	typedef struct {logic [1:0] resp; logic [31:0] data; logic chk;} ubrg_rsp_t;
	typedef struct {logic [7:0] data; int gap;} ubrg_ser_t;
	ubrg_rsp_t exp_rsp[$];
	ubrg_ser_t exp_ser[$];
	ubrg_rsp_t rsp;
	ubrg_ser_t ser;

	ubrg_top ubrg_top_inst (
		.clk_sys(clk_sys), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.external_baud_clock_in(ext_clk), .serial_in_pin(ser_rx), .serial_out_pin(ser_tx)
	);
	ubrg_peer ubrg_peer_inst (
		.clk_sys(clk_sys), .line_in(ser_tx), .line_out(ser_rx),
		.rx_byte(peer_byte), .rx_valid(peer_valid), .gap(peer_gap)
	);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// external base clock: one rising edge every 16 cycles
	always begin
		repeat (8) @(posedge clk_sys);
		ext_clk <= ~ext_clk;
	end

	task automatic give_verdict();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_hs, w_hs, b_hs;
		@(posedge clk_sys);
		exp_rsp.push_back('{r, 32'h0000_0000, 1'b0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b_hs = 1'b0;
		while (!b_hs) begin
			@(negedge clk_sys);
			aw_hs = s_axi_awvalid && s_axi_awready;
			w_hs = s_axi_wvalid && s_axi_wready;
			b_hs = s_axi_bvalid && s_axi_bready;
			@(posedge clk_sys);
			if (aw_hs) s_axi_awvalid <= 1'b0;
			if (w_hs) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r, input logic c);
		logic ar_hs, r_hs;
		@(posedge clk_sys);
		exp_rsp.push_back('{r, d, c});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		r_hs = 1'b0;
		while (!r_hs) begin
			@(negedge clk_sys);
			ar_hs = s_axi_arvalid && s_axi_arready;
			r_hs = s_axi_rvalid && s_axi_rready;
			@(posedge clk_sys);
			if (ar_hs) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask : rd

	// response watcher: handshakes are settled half a cycle before the taking edge
	always @(negedge clk_sys) begin
		if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
			rsp = exp_rsp.pop_front();
			if (s_axi_bvalid) begin
				`CHK("bresp", rsp.resp, s_axi_bresp)
			end else begin
				`CHK("rresp", rsp.resp, s_axi_rresp)
				if (rsp.chk) `CHK("rdata", rsp.data, s_axi_rdata)
			end
		end
	end
	// frame watcher
	always @(posedge clk_sys) begin
		if (peer_valid) begin
			if (exp_ser.size() == 0) begin
				`CHK("frame count", 0, 1)
			end else begin
				ser = exp_ser.pop_front();
				`CHK("frame data", ser.data, peer_byte)
				if (ser.gap != 0) `CHK("frame spacing", ser.gap, peer_gap)
			end
		end
	end

	initial begin
		repeat (90000) @(posedge clk_sys);
		fail_count++;
		give_verdict();
	end

	initial begin
		int seed, per, p, k, code;
		logic [7:0] b0, b1, b2;
		static int cfg [3][2] = '{'{4, 9}, '{5, 8}, '{11, 8}};
		rst = 1'b1;
		ext_clk = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'h1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		fail_count = 0;
		samples_checked = 0;
		seed = $urandom(83);
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		rd(ADDR_CLKSEL, {28'h000_0000, CLKSEL_RESET}, RESP_OKAY, 1'b1);
		rd(ADDR_DIVISOR, {24'h00_0000, DIVISOR_RESET}, RESP_OKAY, 1'b1);
		wr(ADDR_CLKSEL, 32'h0000_00FF, RESP_OKAY);
		rd(ADDR_CLKSEL, 32'h0000_000F, RESP_OKAY, 1'b1);
		wr(8'h20, $urandom, RESP_SLVERR);
		rd(8'h20, 32'h0000_0000, RESP_SLVERR, 1'b0);
		for (int i = 0; i < 3; i++) begin
			code = cfg[i][0];
			k = cfg[i][1];
			p = (code == 11) ? 16 : (1 << code);
			per = 2 * k * p;
			wr(ADDR_MODE, 32'h0000_0000, RESP_OKAY);
			wr(ADDR_CLKSEL, 32'(code), RESP_OKAY);
			wr(ADDR_DIVISOR, 32'(k), RESP_OKAY);
			rd(ADDR_DIVISOR, 32'(k), RESP_OKAY, 1'b1);
			wr(ADDR_MODE, 32'h0000_0007, RESP_OKAY);
			ubrg_peer_inst.bit_cyc = per;
			b0 = 8'($urandom);
			b1 = 8'($urandom);
			b2 = 8'($urandom);
			exp_ser.push_back('{b0, 0});
			exp_ser.push_back('{b1, (20 * k + 2) * p});
			wr(ADDR_TXBUF, {24'h00_0000, b0}, RESP_OKAY);
			repeat (2 * p) @(posedge clk_sys);
			wr(ADDR_TXBUF, {24'h00_0000, b1}, RESP_OKAY);
			rd(ADDR_TXSTAT, 32'h0000_0003, RESP_OKAY, 1'b1);
			while (exp_ser.size() != 0) @(posedge clk_sys);
			repeat (per) @(posedge clk_sys);
			rd(ADDR_TXSTAT, 32'h0000_0000, RESP_OKAY, 1'b1);
			ubrg_peer_inst.send(b2, (i == 1) ? per - per / 40 : per + per / 40);
			repeat (per) @(posedge clk_sys);
			rd(ADDR_RXBUF, {23'h00_0000, 1'b1, b2}, RESP_OKAY, 1'b1);
			rd(ADDR_RXBUF, {24'h00_0000, b2}, RESP_OKAY, 1'b1);
			ubrg_peer_inst.pulse(p);
			repeat (per) @(posedge clk_sys);
			rd(ADDR_RXBUF, {24'h00_0000, b2}, RESP_OKAY, 1'b1);
		end
		give_verdict();
	end
endmodule : ubrg_top_tb
